// File: design/eeh_pkg.sv
package eeh_pkg;
	// Memory geometry
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;
	// Clock
	localparam int CLK_PERIOD_NS = 10;
	// Read access, write pulse and noise filter pulse times
	localparam int READ_ACCESS_NS = 450;
	localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_PULSE_NS = 230;
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NOISE_PULSE_NS = 20;
	localparam int NOISE_PULSE_CYC = (NOISE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Setup and recovery around the strobe
	localparam int SETUP_NS = 10;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVERY_NS = 50;
	localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Worst-case programming time
	localparam int WRITE_CYCLE_MS = 10;
	localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
	// Host command codes
	localparam logic [1:0] CMD_READ = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_WRITE_POLL = 2'h2;
	typedef enum logic [2:0] {
		EEH_IDLE, EEH_SETUP, EEH_READ, EEH_STROBE, EEH_RECOVER, EEH_WAIT, EEH_POLL
	} eeh_state_t;
endpackage

// File: design/eeh_host.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Each access presents an eleven-bit byte address selecting one of 2048 bytes.
// [RULE2] Chip enable is driven low for every read or write access.
// [RULE3] Chip enable is held high between accesses so the memory rests in standby.
// [RULE4] A read holds chip enable and output enable low and samples the data lines.
// [RULE5] A read ends by returning chip enable and output enable high.
// [RULE6] The memory floats its data lines whenever output enable or chip enable is high.
// [RULE7] A write drives chip enable and write enable low with output enable high.
// [RULE8] The address is stable before the later falling strobe edge.
// [RULE9] The data is stable until the earlier rising strobe edge.
// [RULE10] After a write the memory programs by itself, nominally in 5 ms.
// [RULE11] Without polling the host waits 10 ms before any further access.
// [RULE12] The memory floats its data lines during programming, so the host never drives then; the host drives them for 5 cycles after the strobes rise.
// [RULE13] With polling the host rereads the address until the data matches.
// [RULE14] Write strobes are far longer than the 20 ns noise filter.
// [RULE15] Write enable and chip enable stay high out of reset and between writes.
// [RULE16] With chip enable high the memory is in standby whatever the other strobes.
// [RULE17] No new strobe is issued while programming is in progress; polled writes drop chip enable and output enable to reread during it.
module eeh_host import eeh_pkg::*; #(
	parameter int WAIT_CYC = WRITE_CYCLE_CYC,
	parameter int POLL_LIMIT = 65535
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic req_valid,
	input wire logic [1:0] req_cmd,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	output logic rsp_timeout,
	output logic [ADDR_W-1:0] byte_address,
	input wire logic [DATA_W-1:0] data_lines_in,
	output logic [DATA_W-1:0] data_lines_out,
	output logic data_lines_oe,
	output logic ce_n,
	output logic oe_n,
	output logic we_n
);
	// Refuse settings the counters cannot serve; a pulse inside the noise window would never write
	if (WAIT_CYC < 1 || POLL_LIMIT < 1 || WRITE_PULSE_CYC <= NOISE_PULSE_CYC) begin : g_bad_params
		$error("eeh_host: bad parameters");
	end

	////////////////////////////////////////////////////////////////////////////////
	eeh_state_t state, next_state;
	logic [31:0] cnt, next_cnt;
	logic [31:0] polls, next_polls;
	logic [1:0] cmd, next_cmd;
	logic [ADDR_W-1:0] addr, next_addr;
	logic [DATA_W-1:0] wdata, next_wdata, rdata, next_rdata;
	logic ce, next_ce, oe, next_oe, we, next_we, drv, next_drv;
	logic done, next_done, tmo, next_tmo;

	// Next-state logic: one access engine serves reads, writes and polled writes
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_polls = polls;
		next_cmd = cmd;
		next_addr = addr;
		next_wdata = wdata;
		next_rdata = rdata;
		next_ce = ce;
		next_oe = oe;
		next_we = we;
		next_drv = drv;
		next_done = 1'b0;
		next_tmo = 1'b0;
		case (state)
			EEH_IDLE: begin
				if (req_valid) begin
					next_addr = req_addr; // [RULE1] [RULE8]
					next_wdata = req_wdata;
					next_polls = '0;
					next_cnt = 32'(SETUP_CYC);
					next_state = EEH_SETUP;
					// Undefined codes are served as reads, so no stray strobe can reach the array
					if (req_cmd == CMD_WRITE || req_cmd == CMD_WRITE_POLL) begin
						next_cmd = req_cmd;
						next_drv = 1'b1;
					end else begin
						next_cmd = CMD_READ;
						next_drv = 1'b0;
					end
				end
			end
			EEH_SETUP: begin
				// Address settles before any strobe falls
				if (cnt <= 32'd1) begin
					next_ce = 1'b1; // [RULE2]
					if (cmd == CMD_READ) begin
						next_oe = 1'b1; // [RULE4]
						next_cnt = 32'(READ_ACCESS_CYC);
						next_state = EEH_READ;
					end else begin
						next_we = 1'b1; // [RULE7] [RULE15]
						next_cnt = 32'(WRITE_PULSE_CYC); // [RULE14]
						next_state = EEH_STROBE;
					end
				end else begin
					next_cnt = cnt - 32'd1;
				end
			end
			EEH_READ: begin
				if (cnt <= 32'd1) begin
					next_rdata = data_lines_in;
					next_ce = 1'b0; // [RULE5] [RULE3]
					next_oe = 1'b0;
					next_cnt = 32'(RECOVERY_CYC);
					next_state = EEH_RECOVER;
				end else begin
					next_cnt = cnt - 32'd1;
				end
			end
			EEH_STROBE: begin
				if (cnt <= 32'd1) begin
					// Both strobes rise together; data still held this edge [RULE9]
					next_we = 1'b0;
					next_ce = 1'b0;
					next_cnt = 32'(RECOVERY_CYC);
					next_state = EEH_RECOVER;
				end else begin
					next_cnt = cnt - 32'd1;
				end
			end
			EEH_RECOVER: begin
				// Data released only after strobes are high, avoiding a hold violation
				if (cnt <= 32'd1) begin
					next_drv = 1'b0; // [RULE12]
					if (cmd == CMD_READ && polls == '0) begin
						next_done = 1'b1;
						next_state = EEH_IDLE;
					end else if (cmd == CMD_WRITE) begin
						next_cnt = 32'(WAIT_CYC); // [RULE10] [RULE11]
						next_cmd = CMD_READ;
						next_state = EEH_WAIT;
					end else if (cmd == CMD_WRITE_POLL) begin
						next_cmd = CMD_READ;
						next_polls = 32'd1;
						next_state = EEH_POLL;
					end else if (rdata == wdata) begin
						next_done = 1'b1; // [RULE13]
						next_state = EEH_IDLE;
					end else if (polls >= 32'(POLL_LIMIT)) begin
						next_done = 1'b1;
						next_tmo = 1'b1;
						next_state = EEH_IDLE;
					end else begin
						next_polls = polls + 32'd1;
						next_state = EEH_POLL;
					end
				end else begin
					next_cnt = cnt - 32'd1;
				end
			end
			EEH_WAIT: begin
				// Blind wait: no strobe until programming must be over [RULE17]
				if (cnt <= 32'd1) begin
					next_done = 1'b1;
					next_state = EEH_IDLE;
				end else begin
					next_cnt = cnt - 32'd1;
				end
			end
			EEH_POLL: begin
				// Reread the written address; the memory only answers once done [RULE13] [RULE17]
				next_cnt = 32'(SETUP_CYC);
				next_state = EEH_SETUP;
			end
			default: next_state = EEH_IDLE;
		endcase
	end

	// State registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= EEH_IDLE;
			cnt <= '0;
			polls <= '0;
			cmd <= CMD_READ;
			addr <= '0;
			wdata <= '0;
			rdata <= '0;
			ce <= 1'b0; // [RULE15] [RULE16]
			oe <= 1'b0;
			we <= 1'b0;
			drv <= 1'b0;
			done <= 1'b0;
			tmo <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			polls <= next_polls;
			cmd <= next_cmd;
			addr <= next_addr;
			wdata <= next_wdata;
			rdata <= next_rdata;
			ce <= next_ce;
			oe <= next_oe;
			we <= next_we;
			drv <= next_drv;
			done <= next_done;
			tmo <= next_tmo;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin and response drive; strobes are active-high internally
	assign req_ready = (state == EEH_IDLE);
	assign rsp_valid = done;
	assign rsp_rdata = rdata;
	assign rsp_timeout = tmo;
	assign byte_address = addr;
	assign data_lines_out = wdata;
	assign data_lines_oe = drv;
	assign ce_n = ~ce;
	assign oe_n = ~oe;
	assign we_n = ~we;

	////////////////////////////////////////////////////////////////////////////////
	chk_no_drive_read: assert property (@(posedge clk) disable iff (!nrst) !(oe && drv)) // [RULE6]
		else $error("data driven while output enable low");
	chk_write_combo: assert property (@(posedge clk) disable iff (!nrst) we |-> (ce && !oe)) // [RULE7]
		else $error("write strobe without chip enable or with output enable");
	chk_write_pulse_len: assert property (@(posedge clk) disable iff (!nrst)
		$rose(we) |-> we [*8]) // [RULE14]
		else $error("write pulse too short");
	chk_data_held: assert property (@(posedge clk) disable iff (!nrst) $fell(we) |-> drv) // [RULE9]
		else $error("data released before strobe rose");
	chk_addr_stable: assert property (@(posedge clk) disable iff (!nrst) ce |-> $stable(addr)) // [RULE8]
		else $error("address moved during access");
	chk_read_ends: assert property (@(posedge clk) disable iff (!nrst)
		(state == EEH_READ && cnt == 32'd1) |=> (!ce && !oe)) // [RULE5]
		else $error("read not ended");
	chk_standby_idle: assert property (@(posedge clk) disable iff (!nrst) (state == EEH_IDLE) |-> !ce) // [RULE3]
		else $error("chip enabled while idle");
	chk_wait_quiet: assert property (@(posedge clk) disable iff (!nrst)
		(state == EEH_WAIT) |-> (!ce && !we && !drv)) // [RULE11]
		else $error("activity during programming wait");
endmodule

// File: testbench/eeh_mem.sv
`timescale 1ns/1ps
module eeh_mem import eeh_pkg::*; #(
	parameter int PROG_NS = 2000
) (
	input wire logic [ADDR_W-1:0] byte_address,
	input wire logic [DATA_W-1:0] data_lines_out,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic wear_out,
	output logic [DATA_W-1:0] data_lines_in
);
	logic [DATA_W-1:0] mem [2**ADDR_W];
	logic [DATA_W-1:0] pend;
	logic [ADDR_W-1:0] wa;
	logic wr = 1'b0;
	logic busy = 1'b0;
	int strobes_busy = 0;
	realtime t0;
	// Preload distinct within each 256-byte block so a wrong low address byte shows
	initial begin
		for (int i = 0; i < 2**ADDR_W; i++) mem[i] = 8'(i) ^ 8'h5a;
	end
	// Address latched at the later falling strobe; strobes while programming are dropped
	always @(negedge ce_n or negedge we_n) begin
		if (busy && !ce_n && !we_n) strobes_busy++;
		if (!ce_n && !we_n && oe_n && !busy) begin
			wa = byte_address;
			wr = 1'b1;
			t0 = $realtime;
		end
	end
	// Data latched at the earlier rising strobe, then self-timed programming
	always @(posedge ce_n or posedge we_n) begin
		if (wr) begin
			wr = 1'b0;
			if ($realtime - t0 >= 20.0) begin
				pend = data_lines_out;
				busy = 1'b1;
				// A worn cell runs the full cycle but keeps its old byte
				#(PROG_NS) if (!wear_out) mem[wa] = pend;
				busy = 1'b0;
			end
		end
	end
	// Released lines show the inverse, not a stale copy, so a floating bus never looks valid
	assign data_lines_in = (!ce_n && !oe_n && !busy) ? mem[byte_address] :
		(busy ? ~pend : ~mem[byte_address]);
endmodule

// File: testbench/byte_wide_eeprom_access_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
	$display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module byte_wide_eeprom_access_tb import eeh_pkg::*;;
	typedef struct {logic [1:0] cmd; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d;} eeh_row_t;
	logic clk = 0, nrst = 0, req_valid = 0, req_ready, rsp_valid, rsp_timeout, oe, ce_n, oe_n, we_n;
	logic stuck = 0;
	logic [1:0] req_cmd = 0;
	logic [ADDR_W-1:0] req_addr = 0, byte_address;
	logic [DATA_W-1:0] req_wdata = 0, rsp_rdata, din, dout;
	int miscompares = 0, n_tests = 0, clash = 0;
	// Write rows carry the byte to store, read rows the byte expected back
	// Code 3 is undefined and must be served as a plain read
	eeh_row_t rows [12] = '{'{CMD_WRITE, 11'h7ff, 8'ha5}, '{CMD_READ, 11'h7ff, 8'ha5},
		'{CMD_WRITE_POLL, 11'h000, 8'h3c}, '{CMD_READ, 11'h000, 8'h3c}, '{CMD_READ, 11'h123, 8'h79},
		'{CMD_WRITE_POLL, 11'h400, 8'hff}, '{CMD_READ, 11'h400, 8'hff}, '{CMD_READ, 11'h3ff, 8'ha5},
		'{CMD_WRITE, 11'h7ff, 8'h5a}, '{CMD_WRITE_POLL, 11'h7ff, 8'hc3}, '{CMD_READ, 11'h7ff, 8'hc3},
		'{2'h3, 11'h0aa, 8'hf0}};
	always #5 clk = ~clk;
	eeh_host #(.WAIT_CYC(300), .POLL_LIMIT(20)) DUT (.clk(clk), .nrst(nrst), .req_valid(req_valid),
		.req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_timeout(rsp_timeout),
		.byte_address(byte_address), .data_lines_in(din), .data_lines_out(dout), .data_lines_oe(oe),
		.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
	eeh_mem #(.PROG_NS(2000)) mem_model (.byte_address(byte_address), .data_lines_out(dout),
		.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .wear_out(stuck), .data_lines_in(din));
	// Both sides driving the data lines at once is bus contention
	always @(negedge clk) if (nrst && !ce_n && !oe_n && oe) clash++;
	////////////////////////////////////////////////////////////////
	task automatic results();
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// One request, held until taken, then a bounded wait for the completion pulse
	task automatic run(input eeh_row_t r, input logic exp_tmo = 1'b0);
		@(posedge clk);
		{req_valid, req_cmd, req_addr, req_wdata} <= {1'b1, r.cmd, r.a, r.d};
		do @(posedge clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		for (int k = 0; k < 2000; k++) begin
			@(negedge clk);
			if (rsp_valid === 1'b1) break;
		end
		`CHK("rsp_valid", 1'b1, rsp_valid)
		`CHK("rsp_timeout", exp_tmo, rsp_timeout)
		if (r.cmd != CMD_WRITE && r.cmd != CMD_WRITE_POLL) `CHK("rsp_rdata", r.d, rsp_rdata)
		@(negedge clk);
		`CHK("ce_n idle", 1'b1, ce_n)
	endtask
	task automatic chk_rst();
		`CHK("ce_n rst", 1'b1, ce_n)
		`CHK("we_n rst", 1'b1, we_n)
		`CHK("ready rst", 1'b1, req_ready)
		`CHK("addr rst", 11'h000, byte_address)
		`CHK("rsp rst", 1'b0, rsp_valid)
	endtask
	////////////////////////////////////////////////////////////////
	// Watchdog sized well past the longest expected run
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		results();
	end
	initial begin
		repeat (3) @(negedge clk);
		chk_rst();
		@(posedge clk) nrst <= 1'b1;
		foreach (rows[i]) begin
			run(rows[i]);
			$display("test %0d done", i);
		end
		// Reset in mid-read must return chip enable and write enable high at once
		@(posedge clk);
		{req_valid, req_cmd, req_addr} <= {1'b1, CMD_READ, 11'h055};
		@(posedge clk) req_valid <= 1'b0;
		repeat (10) @(posedge clk);
		nrst <= 1'b0;
		@(negedge clk);
		chk_rst();
		@(posedge clk) nrst <= 1'b1;
		run('{CMD_READ, 11'h055, 8'h0f});
		$display("test reset done");
		// A cell that never takes its byte must end polling in a timeout, never a hang
		@(posedge clk) stuck <= 1'b1;
		run('{CMD_WRITE_POLL, 11'h2aa, 8'h00}, 1'b1);
		@(posedge clk) stuck <= 1'b0;
		run('{CMD_READ, 11'h2aa, 8'hf0});
		`CHK("busy strobes", 0, mem_model.strobes_busy)
		`CHK("contention", 0, clash)
		$display("test timeout done");
		results();
	end
endmodule
